// ===== hdl/peb_top.sv
// Peripheral interrupt enable bank with AXI4-Lite registers.
// Assumes peripheral flags are driven by logic on clk_sys_in.
`timescale 1ns/1ps
module peb_top
#(
  parameter bit SMALL_MEMORY = 1'b0,
  parameter bit SER2_WRITABLE = 1'b0
)
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // AXI4-Lite write channels.
  input wire logic [peb_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [peb_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels.
  input wire logic [peb_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [peb_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Peripheral request flags.
  input wire logic [7:0] periph_flags1_in,
  input wire logic [7:0] periph_flags2_in,
  input wire logic [7:0] periph_flags3_in,
  input wire logic [7:0] periph_flags4_in,
  // Requests toward the core and software.
  output logic periph_irq_out,
  output logic irq_out
);

  // ==========================================================
  // Declarations.
  // ==========================================================
  logic [7:0] en_reg [4];
  logic [7:0] flags [4];
  logic [7:0] gated [4];
  logic [1:0] ctrl_reg;
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic [3:0] mask_reg;
  logic [3:0] grp_req;
  logic [3:0] grp_req_reg;
  logic [3:0] grp_rise;
  logic [7:0] en4_mask;
  logic [7:0] en3_mask;
  logic any_req;
  logic gate_open;
  logic wr_stb;
  logic [peb_pkg::ADDR_W-1:0] wr_addr;
  logic [peb_pkg::DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic wr_lane0;
  logic rd_stb;
  logic [peb_pkg::DATA_W-1:0] rd_data;
  logic rd_ok;

  // Implemented masks depend on the part variant.
  assign en4_mask = SMALL_MEMORY ? peb_pkg::MASK_EN4_SMALL
                                 : peb_pkg::MASK_EN4_FULL; // [RL9]
  assign en3_mask = SER2_WRITABLE
                  ? (peb_pkg::MASK_EN3_RW | peb_pkg::MASK_EN3_SER2)
                  : peb_pkg::MASK_EN3_RW; // [RL7]
  assign flags[0] = periph_flags1_in;
  assign flags[1] = periph_flags2_in;
  assign flags[2] = periph_flags3_in;
  assign flags[3] = periph_flags4_in;

  // ==========================================================
  // Bus front end.
  // ==========================================================
  peb_axil_slave u_slave
  (
    .clk_sys_in (clk_sys_in),
    .rst_in (rst_in),
    .awaddr_in (s_axi_awaddr_in),
    .awvalid_in (s_axi_awvalid_in),
    .awready_out (s_axi_awready_out),
    .wdata_in (s_axi_wdata_in),
    .wstrb_in (s_axi_wstrb_in),
    .wvalid_in (s_axi_wvalid_in),
    .wready_out (s_axi_wready_out),
    .bresp_out (s_axi_bresp_out),
    .bvalid_out (s_axi_bvalid_out),
    .bready_in (s_axi_bready_in),
    .araddr_in (s_axi_araddr_in),
    .arvalid_in (s_axi_arvalid_in),
    .arready_out (s_axi_arready_out),
    .rdata_out (s_axi_rdata_out),
    .rresp_out (s_axi_rresp_out),
    .rvalid_out (s_axi_rvalid_out),
    .rready_in (s_axi_rready_in),
    .wr_stb_out (wr_stb),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb),
    .wr_ok_in (wr_ok),
    .rd_stb_out (rd_stb),
    .rd_data_in (rd_data),
    .rd_ok_in (rd_ok)
  );

  // Registers are one byte wide, so only lane 0 can change them.
  assign wr_lane0 = wr_stb && wr_strb[0];

  // Write decode: known offsets answer OKAY, others SLVERR.
  always_comb
  begin
    unique case (wr_addr)
      peb_pkg::OFS_PERIPH_INT_ENABLE_1,
      peb_pkg::OFS_PERIPH_INT_ENABLE_2,
      peb_pkg::OFS_PERIPH_INT_ENABLE_3,
      peb_pkg::OFS_PERIPH_INT_ENABLE_4,
      peb_pkg::OFS_GLOBAL_CTRL,
      peb_pkg::OFS_FLAG_VIEW,
      peb_pkg::OFS_EVENT_STATUS,
      peb_pkg::OFS_EVENT_MASK,
      peb_pkg::OFS_REQUEST_VIEW: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Read mux; unused upper bits read as zero.
  always_comb
  begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_in)
      peb_pkg::OFS_PERIPH_INT_ENABLE_1: rd_data[7:0] = en_reg[0];
      peb_pkg::OFS_PERIPH_INT_ENABLE_2: rd_data[7:0] = en_reg[1];
      peb_pkg::OFS_PERIPH_INT_ENABLE_3: rd_data[7:0] = en_reg[2];
      peb_pkg::OFS_PERIPH_INT_ENABLE_4: rd_data[7:0] = en_reg[3];
      peb_pkg::OFS_GLOBAL_CTRL: rd_data[1:0] = ctrl_reg;
      peb_pkg::OFS_FLAG_VIEW:
        rd_data = {flags[3], flags[2], flags[1], flags[0]};
      peb_pkg::OFS_EVENT_STATUS: rd_data[3:0] = status_reg;
      peb_pkg::OFS_EVENT_MASK: rd_data[3:0] = mask_reg;
      peb_pkg::OFS_REQUEST_VIEW:
        rd_data = {gated[3], gated[2], gated[1], gated[0]};
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Enable registers.
  // ==========================================================
  // Writes keep only implemented bits; the rest stay zero.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      en_reg[0] <= peb_pkg::RST_EN; // [RL2]
      en_reg[1] <= peb_pkg::RST_EN; // [RL2]
      en_reg[2] <= peb_pkg::RST_EN; // [RL2]
      en_reg[3] <= peb_pkg::RST_EN; // [RL2]
    end
    else if (wr_lane0)
    begin
      if (wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_1)
      begin
        en_reg[0] <= wr_data[7:0] & peb_pkg::MASK_EN1; // [RL3]
      end
      if (wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_2)
      begin
        en_reg[1] <= wr_data[7:0] & peb_pkg::MASK_EN2; // [RL4] [RL5]
      end
      if (wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_3)
      begin
        en_reg[2] <= wr_data[7:0] & en3_mask; // [RL6] [RL5] [RL7]
      end
      if (wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_4)
      begin
        en_reg[3] <= wr_data[7:0] & en4_mask; // [RL8] [RL9]
      end
    end
  end

  // Global peripheral enable and priority-level selection.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      ctrl_reg <= peb_pkg::RST_CTRL;
    end
    else if (wr_lane0 && wr_addr == peb_pkg::OFS_GLOBAL_CTRL)
    begin
      ctrl_reg <= wr_data[1:0] & peb_pkg::MASK_CTRL;
    end
  end

  // ==========================================================
  // Request gating.
  // ==========================================================
  // Each flag is ANDed with its enable; flags are only read.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_grp
      assign gated[g] = flags[g] & en_reg[g]; // [RL1]
      assign grp_req[g] = |gated[g]; // [RL12]
    end
  endgenerate

  // With priority levels off the global enable must be set too.
  assign gate_open = ctrl_reg[peb_pkg::BIT_PRIORITY_LEVELS_EN]
                   | ctrl_reg[peb_pkg::BIT_GLOBAL_PERIPH_INT_EN]; // [RL10]
  assign any_req = |grp_req; // [RL12]

  // The core request is registered to give a clean level.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      periph_irq_out <= 1'b0;
    end
    else
    begin
      periph_irq_out <= any_req && gate_open; // [RL12] [RL10]
    end
  end

  // ==========================================================
  // Software event status and mask.
  // ==========================================================
  // A group raises an event when its gated request appears.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      grp_req_reg <= peb_pkg::RST_EVENT;
    end
    else
    begin
      grp_req_reg <= grp_req;
    end
  end

  assign grp_rise = grp_req & ~grp_req_reg;

  // Writing one clears a bit, but a new event in that cycle wins.
  always_comb
  begin
    status_next = status_reg;
    if (wr_lane0 && wr_addr == peb_pkg::OFS_EVENT_STATUS)
    begin
      status_next = status_reg & ~wr_data[3:0];
    end
    status_next = status_next | grp_rise;
  end

  // Status and mask storage.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      status_reg <= peb_pkg::RST_EVENT;
      mask_reg <= peb_pkg::RST_EVENT;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_lane0 && wr_addr == peb_pkg::OFS_EVENT_MASK)
      begin
        mask_reg <= wr_data[3:0] & peb_pkg::MASK_EVENT;
      end
    end
  end

  // Interrupt line is high while any unmasked status bit is set.
  assign irq_out = |(status_reg & mask_reg);

  // ==========================================================
  // Assertions.
  // ==========================================================
  // Enables are all zero right after reset release.
  a_reset_clears_en: // [RL2]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $fell(rst_in) |-> (en_reg[0] == 8'h00 && en_reg[1] == 8'h00
        && en_reg[2] == 8'h00 && en_reg[3] == 8'h00
        && !periph_irq_out))
    else $error("Enable bits not cleared by reset.");

  // An enabled flag of the first group with the gate open raises the core request.
  a_enabled_flag_irq: // [RL1]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (|(flags[0] & en_reg[0]) && gate_open) |=> periph_irq_out)
    else $error("Enabled flag did not raise the request.");

  // No enabled flag means no request one cycle later.
  a_no_req_quiet: // [RL12]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (gated[0] == 8'h00 && gated[1] == 8'h00 && gated[2] == 8'h00
        && gated[3] == 8'h00) |=> !periph_irq_out)
    else $error("Request raised with no enabled flag.");

  // The global enable blocks all requests without priority levels.
  a_global_gate: // [RL10]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_reg == 2'h0) [*2] |-> !periph_irq_out)
    else $error("Request passed a closed global gate.");

  // Bit 6 of the second and third registers stays zero.
  a_bit6_zero: // [RL5]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !en_reg[1][peb_pkg::BIT_UNIMPL] && !en_reg[2][peb_pkg::BIT_UNIMPL])
    else $error("Unimplemented bit 6 reads as one.");

  // Serial2 enables stay zero when they are read-only.
  a_ser2_readonly: // [RL7]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !SER2_WRITABLE |-> (en_reg[2][peb_pkg::BIT_SERIAL2_RX_EN] == 1'b0
        && en_reg[2][peb_pkg::BIT_SERIAL2_TX_EN] == 1'b0))
    else $error("Read-only serial2 enable changed.");

  // Small parts never show capcmp ten or nine enabled.
  a_small_memory: // [RL9]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      SMALL_MEMORY |-> en_reg[3][7:6] == 2'h0)
    else $error("Absent capcmp enable became set.");

  // A lane-0 write to the first register lands all eight bits.
  a_reg1_write: // [RL3]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_lane0 && wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_1)
      |=> en_reg[0] == $past(wr_data[7:0]))
    else $error("First enable register write lost.");

  // A write to the second register keeps its documented bits.
  a_reg2_write: // [RL4]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_lane0 && wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_2)
      |=> en_reg[1] == ($past(wr_data[7:0]) & peb_pkg::MASK_EN2))
    else $error("Second enable register write wrong.");

  // The MASK_EN3_RW bits of the third register follow a write.
  a_reg3_write: // [RL6]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_lane0 && wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_3)
      |=> (en_reg[2] & peb_pkg::MASK_EN3_RW)
        == ($past(wr_data[7:0]) & peb_pkg::MASK_EN3_RW))
    else $error("Third enable register write wrong.");

  // The fourth register holds all implemented capcmp enables.
  a_reg4_write: // [RL8]
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_lane0 && wr_addr == peb_pkg::OFS_PERIPH_INT_ENABLE_4)
      |=> en_reg[3] == ($past(wr_data[7:0]) & $past(en4_mask)))
    else $error("Fourth enable register write wrong.");

  // A new event of the first group sets its status bit even during a clear.
  a_event_sticky:
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      grp_rise[0] |=> status_reg[0] ##1 (status_reg[0]
        || $past(wr_lane0 && wr_addr == peb_pkg::OFS_EVENT_STATUS)))
    else $error("Group event lost from status.");

  // A completed write is answered on the next cycle.
  a_write_answer:
    assert property (@(posedge clk_sys_in) disable iff (rst_in)
      wr_stb |=> s_axi_bvalid_out && s_axi_bresp_out == (wr_ok
        ? peb_pkg::RESP_OKAY : peb_pkg::RESP_SLVERR) [*1])
    else $error("Write response missing or wrong.");

endmodule

// ===== hdl/peb_pkg.sv
// Constants for the peripheral interrupt enable bank.
// Assumes a single system clock and an AXI4-Lite register master.
//
// Notes on behaviour
// [RL1] Enable bit passes its flag, never alters it.
// [RL2] All implemented enable bits reset to zero.
// [RL3] First register: eight serial, timer, converter enables.
// [RL4] Second register: oscillator, serial, collision, voltage, timer3.
// [RL5] Bit 6 of registers two, three reads zero.
// [RL6] Third register: timer5, serial2, charge, capcmp, clock.
// [RL7] Serial2 receive/transmit enables are read-only zero; the code makes them writable when SER2_WRITABLE is set.
// [RL8] Fourth register: capcmp units ten down to three.
// [RL9] Small-memory parts lack capcmp ten and nine.
// [RL10] Without priority levels, global enable also required.
// [RL11] Software clears peripheral flags after servicing them.
// [RL12] One request: OR of flag AND enable.
package peb_pkg;

  // ==========================================================
  // Bus geometry.
  // ==========================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register offsets.
  // ==========================================================
  localparam logic [7:0] OFS_PERIPH_INT_ENABLE_1 = 8'h00;
  localparam logic [7:0] OFS_PERIPH_INT_ENABLE_2 = 8'h04;
  localparam logic [7:0] OFS_PERIPH_INT_ENABLE_3 = 8'h08;
  localparam logic [7:0] OFS_PERIPH_INT_ENABLE_4 = 8'h0c;
  localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h10;
  localparam logic [7:0] OFS_FLAG_VIEW = 8'h14;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h1c;
  localparam logic [7:0] OFS_REQUEST_VIEW = 8'h20;

  // ==========================================================
  // Field positions and implemented-bit masks.
  // ==========================================================
  localparam int BIT_PAR_SLAVE_RW_EN = 7;
  localparam int BIT_TIMER1_OVF_EN = 0;
  localparam int BIT_OSC_FAIL_EN = 7;
  localparam int BIT_UNIMPL = 6;
  localparam int BIT_SYNC_SERIAL2_EN = 5;
  localparam int BIT_TIMER3_GATE_EN = 0;
  localparam int BIT_TIMER5_GATE_EN = 7;
  localparam int BIT_SERIAL2_RX_EN = 5;
  localparam int BIT_SERIAL2_TX_EN = 4;
  localparam int BIT_RTC_ALARM_EN = 0;
  localparam int BIT_GLOBAL_PERIPH_INT_EN = 0;
  localparam int BIT_PRIORITY_LEVELS_EN = 1;
  localparam logic [7:0] MASK_EN1 = 8'hff;
  localparam logic [7:0] MASK_EN2 = 8'hbf;
  localparam logic [7:0] MASK_EN3_RW = 8'h8f;
  localparam logic [7:0] MASK_EN3_SER2 = 8'h30;
  localparam logic [7:0] MASK_EN4_FULL = 8'hff;
  localparam logic [7:0] MASK_EN4_SMALL = 8'h3f;
  localparam logic [1:0] MASK_CTRL = 2'h3;
  localparam logic [3:0] MASK_EVENT = 4'hf;

  // ==========================================================
  // Reset values.
  // ==========================================================
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [3:0] RST_EVENT = 4'h0;

endpackage

// ===== hdl/peb_axil_slave.sv
// AXI4-Lite slave front end for the enable bank.
// Assumes a master on clk_sys_in; decode is done by the parent.
`timescale 1ns/1ps
module peb_axil_slave
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Write channels.
  input wire logic [peb_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [peb_pkg::DATA_W-1:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // Read channels.
  input wire logic [peb_pkg::ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [peb_pkg::DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Register side.
  output logic wr_stb_out,
  output logic [peb_pkg::ADDR_W-1:0] wr_addr_out,
  output logic [peb_pkg::DATA_W-1:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic rd_stb_out,
  input wire logic [peb_pkg::DATA_W-1:0] rd_data_in,
  input wire logic rd_ok_in
);

  logic aw_full_reg;
  logic w_full_reg;

  // Address and data are taken in either order, then held.
  assign awready_out = !aw_full_reg && !bvalid_out;
  assign wready_out = !w_full_reg && !bvalid_out;
  assign wr_stb_out = aw_full_reg && w_full_reg && !bvalid_out;
  assign arready_out = !rvalid_out;
  assign rd_stb_out = arvalid_in && arready_out;

  // Write capture and response.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= peb_pkg::RESP_OKAY;
      wr_addr_out <= '0;
      wr_data_out <= '0;
      wr_strb_out <= 4'h0;
    end
    else
    begin
      if (awvalid_in && awready_out)
      begin
        aw_full_reg <= 1'b1;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out)
      begin
        w_full_reg <= 1'b1;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (wr_stb_out)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= wr_ok_in ? peb_pkg::RESP_OKAY : peb_pkg::RESP_SLVERR;
      end
      else if (bvalid_out && bready_in)
      begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // Read data is registered at the same edge that takes the address.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= peb_pkg::RESP_OKAY;
    end
    else if (rd_stb_out)
    begin
      rvalid_out <= 1'b1;
      rdata_out <= rd_data_in;
      rresp_out <= rd_ok_in ? peb_pkg::RESP_OKAY : peb_pkg::RESP_SLVERR;
    end
    else if (rvalid_out && rready_in)
    begin
      rvalid_out <= 1'b0;
    end
  end

endmodule

// ===== test/peb_flag_model.sv
// Model of the peripheral flag sources that feed the enable bank.
// Assumes set and clear commands from the bench on clk_sys_in.
`timescale 1ns/1ps
module peb_flag_model
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Commands from the bench, one bit for each flag.
  input wire logic [31:0] set_in,
  input wire logic [31:0] clr_in,
  // Flags toward the bank.
  output logic [7:0] flags1_out,
  output logic [7:0] flags2_out,
  output logic [7:0] flags3_out,
  output logic [7:0] flags4_out
);
  logic [31:0] flags_reg;

  // ==========================================================
  // Flag storage
  // ==========================================================
  // Hardware sets a flag, and only a software clear removes it.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      flags_reg <= 32'h0;
    end
    else
    begin
      flags_reg <= (flags_reg | set_in) & ~clr_in;
    end
  end

  // Each group of eight flags goes to its own port.
  assign flags1_out = flags_reg[7:0];
  assign flags2_out = flags_reg[15:8];
  assign flags3_out = flags_reg[23:16];
  assign flags4_out = flags_reg[31:24];
endmodule

// ===== test/testbench.sv
// Self-checking bench for the enable bank over AXI4-Lite.
// Assumes peb_pkg, peb_top and peb_flag_model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in;
  logic rst_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, f_set, f_clr;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_core, irq_sw;
  logic [1:0] bresp, rresp;
  logic [7:0] flags1, flags2, flags3, flags4;
  logic [7:0] en_ones [4] = '{8'hff, 8'hbf, 8'h8f, 8'hff};
  int fail_count = 0;
  int cmp_count = 0;

  // ==========================================================
  // Design, flag sources and clock
  // ==========================================================
  peb_top i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .periph_flags1_in(flags1),
    .periph_flags2_in(flags2), .periph_flags3_in(flags3),
    .periph_flags4_in(flags4), .periph_irq_out(irq_core),
    .irq_out(irq_sw));
  peb_flag_model i_flags (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .set_in(f_set), .clr_in(f_clr), .flags1_out(flags1),
    .flags2_out(flags2), .flags3_out(flags3), .flags4_out(flags4));

  // The clock toggles every half period of 12.5 ns.
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares one value with case equality and counts it.
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      fail_count++;
    end
  endtask

  // Write cycle: each channel is released at the edge that takes it.
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    tb = 1'b0;
    @(posedge clk_sys_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 50)
    begin
      @(negedge clk_sys_in);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk_sys_in);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, r});
    if (!tb)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // Read cycle with a check of data and response.
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex,
    input logic [1:0] er, input string nm);
    int n;
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    tb = 1'b0;
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tb && n < 50)
    begin
      @(negedge clk_sys_in);
      ta = arvalid && arready;
      tb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys_in);
      if (ta)
        arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    chk(nm, ex, d);
    chk("read response", {30'h0, er}, {30'h0, r});
    if (!tb)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // Pulses set and clear commands to the flag sources, then settles.
  task automatic flg(input logic [31:0] s, input logic [31:0] c);
    @(posedge clk_sys_in);
    f_set <= s;
    f_clr <= c;
    @(posedge clk_sys_in);
    f_set <= 32'h0;
    f_clr <= 32'h0;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    rst_in = 1'b1;
    {awaddr, araddr, wdata, f_set, f_clr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Reset value, all-ones image and clearing of each enable register.
    for (int i = 0; i < 4; i++)
    begin
      rdc(8'(4 * i), 32'h0, peb_pkg::RESP_OKAY, "enable reset");
      wrc(8'(4 * i), 32'hffffffff, peb_pkg::RESP_OKAY);
      rdc(8'(4 * i), {24'h0, en_ones[i]}, peb_pkg::RESP_OKAY,
        "ones");
      wrc(8'(4 * i), 32'h0, peb_pkg::RESP_OKAY);
      rdc(8'(4 * i), 32'h0, peb_pkg::RESP_OKAY, "enable cleared");
    end
    rdc(peb_pkg::OFS_GLOBAL_CTRL, 32'h0, peb_pkg::RESP_OKAY,
      "ctrl reset");
    rdc(peb_pkg::OFS_EVENT_MASK, 32'h0, peb_pkg::RESP_OKAY,
      "mask reset");
    // A write without byte lane 0 answers OKAY and changes nothing.
    wstrb <= 4'he;
    wrc(peb_pkg::OFS_PERIPH_INT_ENABLE_1, 32'hff, peb_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rdc(peb_pkg::OFS_PERIPH_INT_ENABLE_1, 32'h0, peb_pkg::RESP_OKAY, "lane0");
    // An unmapped address is refused on both channels.
    wrc(8'h24, 32'h1, peb_pkg::RESP_SLVERR);
    rdc(8'h24, 32'h0, peb_pkg::RESP_SLVERR, "unmapped");
    // Bit 0 source of every group is gated by its own enable.
    wrc(peb_pkg::OFS_GLOBAL_CTRL, 32'h1, peb_pkg::RESP_OKAY);
    for (int g = 0; g < 4; g++)
    begin
      flg(32'h1 << (8 * g), 32'h0);
      chk("request blocked", 32'h0, irq_core);
      wrc(8'(4 * g), 32'h1, peb_pkg::RESP_OKAY);
      flg(32'h0, 32'h0);
      chk("request passed", 32'h1, irq_core);
      rdc(peb_pkg::OFS_FLAG_VIEW, 32'h1 << (8 * g), peb_pkg::RESP_OKAY,
        "flags");
      wrc(8'(4 * g), 32'h0, peb_pkg::RESP_OKAY);
      flg(32'h0, 32'hffffffff);
    end
    // Every group rose once: status sticks, mask gates, ones clear.
    rdc(peb_pkg::OFS_EVENT_STATUS, 32'hf, peb_pkg::RESP_OKAY, "status");
    chk("masked irq", 32'h0, irq_sw);
    wrc(peb_pkg::OFS_EVENT_MASK, 32'h4, peb_pkg::RESP_OKAY);
    chk("unmasked irq", 32'h1, irq_sw);
    wrc(peb_pkg::OFS_EVENT_STATUS, 32'hb, peb_pkg::RESP_OKAY);
    chk("irq after other clear", 32'h1, irq_sw);
    wrc(peb_pkg::OFS_EVENT_STATUS, 32'h4, peb_pkg::RESP_OKAY);
    chk("irq cleared", 32'h0, irq_sw);
    // Serial 2 receive enable cannot be set.
    flg(32'h00280000, 32'h0);
    wrc(peb_pkg::OFS_PERIPH_INT_ENABLE_3, 32'h20, peb_pkg::RESP_OKAY);
    flg(32'h0, 32'h0);
    chk("read-only enable", 32'h0, irq_core);
    // Charge time source with the global and priority controls.
    wrc(peb_pkg::OFS_PERIPH_INT_ENABLE_3, 32'h08, peb_pkg::RESP_OKAY);
    flg(32'h0, 32'h0);
    chk("charge request", 32'h1, irq_core);
    wrc(peb_pkg::OFS_GLOBAL_CTRL, 32'h0, peb_pkg::RESP_OKAY);
    flg(32'h0, 32'h0);
    chk("global off", 32'h0, irq_core);
    wrc(peb_pkg::OFS_GLOBAL_CTRL, 32'h2, peb_pkg::RESP_OKAY);
    flg(32'h0, 32'h0);
    chk("priority on", 32'h1, irq_core);
    flg(32'h0, 32'hffffffff);
    chk("flags cleared", 32'h0, irq_core);
    // The flag view ignores writes.
    wrc(peb_pkg::OFS_FLAG_VIEW, 32'hff, peb_pkg::RESP_OKAY);
    rdc(peb_pkg::OFS_FLAG_VIEW, 32'h0, peb_pkg::RESP_OKAY, "view");
    report_and_stop();
  end
endmodule
